// ---- hdl/dcb_pkg.sv ----
// Purpose: Shared constants for the dual counter with byte readout
// Assumes: One system clock at 25 MHz; all pins sampled in that domain
// Notes:   Host map offsets and timing counts live here
package dcb_pkg;
   localparam int          CNT_W        = 16;
   localparam int          BYTE_W       = 8;
   localparam logic [15:0] CNT_RESET    = 16'h0000;
   localparam logic [15:0] CNT_FULL     = 16'hffff;
   localparam logic [31:0] STORE_RESET  = 32'h0000_0000;
   localparam int          A_LO_POS     = 0;
   localparam int          A_HI_POS     = 8;
   localparam int          B_LO_POS     = 16;
   localparam int          B_HI_POS     = 24;
   // Host byte map
   localparam logic [2:0]  OFS_A_LO     = 3'h0;
   localparam logic [2:0]  OFS_A_HI     = 3'h1;
   localparam logic [2:0]  OFS_B_LO     = 3'h2;
   localparam logic [2:0]  OFS_B_HI     = 3'h3;
   localparam logic [2:0]  OFS_CAPTURE  = 3'h4;
   localparam logic [2:0]  OFS_CLEAR    = 3'h5;
   // Timing
   localparam int          CLK_NS       = 40;
   localparam int          CLEAR_MIN_NS = 20;
   localparam int          CLEAR_CYC    = (CLEAR_MIN_NS + CLK_NS - 1) / CLK_NS + 1;
   localparam int          TZ_NS        = 200;
   localparam int          TZ_CYC       = (TZ_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0]  CLEAR_CYC_W  = 4'(CLEAR_CYC);
   localparam logic [3:0]  TZ_CYC_W     = 4'(TZ_CYC);
endpackage

// ---- hdl/dcb_if.sv ----
// Purpose: Pin bundle between the counter device and its host
// Assumes: Byte bus resolved here from the device output enable
// Notes:   Both count clocks are sampled pins, not clock ports
`timescale 1ns/1ps
`default_nettype none
interface dcb_if;
   logic       count_clock_a;
   logic       count_clock_b;
   logic       capture_clock;
   logic       counter_clear_n;
   logic       carry_out_a_n;
   logic       count_b_enable_n;
   logic       sel_a_low_byte_n;
   logic       sel_a_high_byte_n;
   logic       sel_b_low_byte_n;
   logic       sel_b_high_byte_n;
   logic [7:0] byte_out;
   logic       byte_out_oe;
   logic [7:0] byte_bus;
   // Floating bus reads as all ones, like a pulled-up data bus
   assign byte_bus = byte_out_oe ? byte_out : 8'hff;
   modport dev (input count_clock_a, count_clock_b, capture_clock, counter_clear_n,
                count_b_enable_n, sel_a_low_byte_n, sel_a_high_byte_n,
                sel_b_low_byte_n, sel_b_high_byte_n,
                output carry_out_a_n, byte_out, byte_out_oe);
   modport host (output count_clock_a, count_clock_b, capture_clock, counter_clear_n,
                 count_b_enable_n, sel_a_low_byte_n, sel_a_high_byte_n,
                 sel_b_low_byte_n, sel_b_high_byte_n,
                 input carry_out_a_n, byte_bus);
endinterface
`default_nettype wire

// ---- hdl/dcb_device.sv ----
//
// Contract
// - Two 16-bit counters, each on own clock
// - Carry low while counter A full
// - Counter B clock gated by enable
// - Enable active low, sampled at clock edge
// - System chains clocks and carry for 32 bits
// - Clear low zeroes counters at once
// - Capture edge copies both counts into store
// - Store holds until next capture edge
// - Store split per counter into byte halves
// - One select low drives chosen byte
// - All selects high float the bus
// - Host reads four bytes separately
// - Counts reach 65535 or 4294967295 chained
// - Host holds clear low over 20 ns
// - Host keeps capture and clear glitch free
// - Host map: reads, capture, clear, idle
//
// Purpose: Device end: two counters, capture store, byte readout
// Assumes: Pins arrive asynchronous and pass two flops first
// Notes:   Pin edges seen two to three clk cycles late
`timescale 1ns/1ps
`default_nettype none
module dcb_device (
   input  wire logic clk,
   input  wire logic arst_n,
   dcb_if.dev        pins,
   output logic [15:0] count_a,
   output logic [15:0] count_b,
   output logic [31:0] stored
);
   typedef struct packed {
      logic [2:0]  s_ca;     // Sync stages plus previous for edge detect
      logic [2:0]  s_cb;
      logic [2:0]  s_cap;
      logic [1:0]  s_clr;
      logic [1:0]  s_en;
      logic [1:0]  s_sal;
      logic [1:0]  s_sah;
      logic [1:0]  s_sbl;
      logic [1:0]  s_sbh;
      logic [15:0] cnt_a;
      logic [15:0] cnt_b;
      logic [31:0] store;
      logic        carry_n;
      logic [7:0]  bout;
      logic        oe;
      logic [15:0] cnt_a_o;
      logic [15:0] cnt_b_o;
   } dcb_dev_state_t;

   dcb_dev_state_t st_reg;
   dcb_dev_state_t st_next;

   // Rising edge seen between second sync stage and its delayed copy
   function automatic logic rise(input logic [2:0] s);
      rise = s[1] & ~s[2];
   endfunction

   // ***********************
   // Next state
   // ***********************
   always_comb begin
      logic [15:0] na;
      logic [15:0] nb;
      logic        clr_n;
      na      = st_reg.cnt_a;
      nb      = st_reg.cnt_b;
      clr_n   = st_reg.s_clr[1];
      st_next = st_reg;
      st_next.s_ca  = {st_reg.s_ca[1:0], pins.count_clock_a};
      st_next.s_cb  = {st_reg.s_cb[1:0], pins.count_clock_b};
      st_next.s_cap = {st_reg.s_cap[1:0], pins.capture_clock};
      st_next.s_clr = {st_reg.s_clr[0], pins.counter_clear_n};
      st_next.s_en  = {st_reg.s_en[0], pins.count_b_enable_n};
      st_next.s_sal = {st_reg.s_sal[0], pins.sel_a_low_byte_n};
      st_next.s_sah = {st_reg.s_sah[0], pins.sel_a_high_byte_n};
      st_next.s_sbl = {st_reg.s_sbl[0], pins.sel_b_low_byte_n};
      st_next.s_sbh = {st_reg.s_sbh[0], pins.sel_b_high_byte_n};
      // Counters step by one; full count rolls to zero naturally
      if (rise(st_reg.s_ca)) begin
         na = st_reg.cnt_a + 16'h0001;
      end
      // Enable sampled low at the B edge gates the count
      if (rise(st_reg.s_cb) && !st_reg.s_en[1]) begin
         nb = st_reg.cnt_b + 16'h0001;
      end
      // Clear dominates any count edge in the same cycle
      if (!clr_n) begin
         na = dcb_pkg::CNT_RESET;
         nb = dcb_pkg::CNT_RESET;
      end
      st_next.cnt_a   = na;
      st_next.cnt_b   = nb;
      st_next.cnt_a_o = na;
      st_next.cnt_b_o = nb;
      st_next.carry_n = ~(na == dcb_pkg::CNT_FULL);
      // Store loads only on the capture edge and holds otherwise
      if (rise(st_reg.s_cap)) begin
         st_next.store = {st_reg.cnt_b, st_reg.cnt_a};
      end
      // Byte mux; several selects low is undefined, priority A low first
      st_next.oe   = 1'b1;
      st_next.bout = 8'h00;
      if (!st_reg.s_sal[1]) begin
         st_next.bout = st_reg.store[dcb_pkg::A_LO_POS +: dcb_pkg::BYTE_W];
      end else if (!st_reg.s_sah[1]) begin
         st_next.bout = st_reg.store[dcb_pkg::A_HI_POS +: dcb_pkg::BYTE_W];
      end else if (!st_reg.s_sbl[1]) begin
         st_next.bout = st_reg.store[dcb_pkg::B_LO_POS +: dcb_pkg::BYTE_W];
      end else if (!st_reg.s_sbh[1]) begin
         st_next.bout = st_reg.store[dcb_pkg::B_HI_POS +: dcb_pkg::BYTE_W];
      end else begin
         st_next.oe = 1'b0;
      end
   end

   // ***********************
   // State register
   // ***********************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg         <= '0;
         st_reg.s_clr   <= 2'h3;
         st_reg.s_en    <= 2'h3;
         st_reg.s_sal   <= 2'h3;
         st_reg.s_sah   <= 2'h3;
         st_reg.s_sbl   <= 2'h3;
         st_reg.s_sbh   <= 2'h3;
         st_reg.carry_n <= 1'b1;
         st_reg.store   <= dcb_pkg::STORE_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign pins.carry_out_a_n = st_reg.carry_n;
   assign pins.byte_out      = st_reg.bout;
   assign pins.byte_out_oe   = st_reg.oe;
   assign count_a            = st_reg.cnt_a_o;
   assign count_b            = st_reg.cnt_b_o;
   assign stored             = st_reg.store;
endmodule
`default_nettype wire

// ---- hdl/dcb_host.sv ----
// Purpose: Host end: byte-mapped reads, capture and clear strobes
// Assumes: Counter clocks come from user pulse inputs on clk
// Notes:   One command at a time; busy until it completes
`timescale 1ns/1ps
`default_nettype none
module dcb_host (
   input  wire logic       clk,
   input  wire logic       arst_n,
   dcb_if.host             pins,
   input  wire logic       pulse_a,
   input  wire logic       pulse_b,
   input  wire logic       chain,
   input  wire logic       req,
   input  wire logic [2:0] addr,
   output logic            busy,
   output logic            rd_valid,
   output logic [7:0]      rd_data
);
   typedef enum logic [1:0] {H_IDLE, H_ACT, H_GAP} dcb_hst_t;
   typedef struct packed {
      dcb_hst_t   fsm;
      logic [2:0] ofs;
      logic [3:0] cnt;
      logic       ca;
      logic       cb;
      logic       cap;
      logic       clr_n;
      logic [3:0] sel_n;
      logic [7:0] s_bus0;
      logic [7:0] s_bus1;
      logic       busy;
      logic       rv;
      logic [7:0] rd;
   } dcb_host_state_t;

   dcb_host_state_t st_reg;
   dcb_host_state_t st_next;

   // ***********************
   // Next state
   // ***********************
   always_comb begin
      st_next         = st_reg;
      st_next.rv      = 1'b0;
      st_next.s_bus0  = pins.byte_bus;
      st_next.s_bus1  = st_reg.s_bus0;
      // Pulses drive count clocks; chained mode shares clock A
      st_next.ca = pulse_a;
      st_next.cb = chain ? pulse_a : pulse_b;
      unique case (st_reg.fsm)
         H_IDLE: begin
            if (req) begin
               st_next.fsm  = H_ACT;
               st_next.ofs  = addr;
               st_next.busy = 1'b1;
               st_next.cnt  = 4'h0;
               // One select at a time, offsets 6 and 7 do nothing
               unique case (addr)
                  dcb_pkg::OFS_A_LO:    st_next.sel_n = 4'he;
                  dcb_pkg::OFS_A_HI:    st_next.sel_n = 4'hd;
                  dcb_pkg::OFS_B_LO:    st_next.sel_n = 4'hb;
                  dcb_pkg::OFS_B_HI:    st_next.sel_n = 4'h7;
                  dcb_pkg::OFS_CAPTURE: st_next.cap   = 1'b1;
                  dcb_pkg::OFS_CLEAR:   st_next.clr_n = 1'b0;
                  default:              st_next.sel_n = 4'hf;
               endcase
            end
         end
         H_ACT: begin
            // Hold long enough for device sync plus bus turnaround
            st_next.cnt = st_reg.cnt + 4'h1;
            if (st_reg.cnt == 4'h5 + dcb_pkg::CLEAR_CYC_W) begin
               st_next.fsm   = H_GAP;
               st_next.cnt   = 4'h0;
               st_next.sel_n = 4'hf;
               st_next.cap   = 1'b0;
               st_next.clr_n = 1'b1;
               if (st_reg.ofs < dcb_pkg::OFS_CAPTURE) begin
                  st_next.rv = 1'b1;
                  st_next.rd = st_reg.s_bus1;
               end
            end
         end
         H_GAP: begin
            // All selects high for the quiet period before the next
            st_next.cnt = st_reg.cnt + 4'h1;
            if (st_reg.cnt == 4'h4 + dcb_pkg::TZ_CYC_W) begin
               st_next.fsm  = H_IDLE;
               st_next.busy = 1'b0;
            end
         end
         // Unused fourth code recovers to idle rather than hanging busy
         default: begin
            st_next.fsm  = H_IDLE;
            st_next.busy = 1'b0;
         end
      endcase
   end

   // ***********************
   // State register
   // ***********************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg         <= '0;
         st_reg.fsm     <= H_IDLE;
         st_reg.clr_n   <= 1'b1;
         st_reg.sel_n   <= 4'hf;
      end else begin
         st_reg <= st_next;
      end
   end

   // Carry drives B enable directly in chained mode
   assign pins.count_b_enable_n  = chain ? pins.carry_out_a_n : 1'b0;
   assign pins.count_clock_a     = st_reg.ca;
   assign pins.count_clock_b     = st_reg.cb;
   assign pins.capture_clock     = st_reg.cap;
   assign pins.counter_clear_n   = st_reg.clr_n;
   assign pins.sel_a_low_byte_n  = st_reg.sel_n[0];
   assign pins.sel_a_high_byte_n = st_reg.sel_n[1];
   assign pins.sel_b_low_byte_n  = st_reg.sel_n[2];
   assign pins.sel_b_high_byte_n = st_reg.sel_n[3];
   assign busy                   = st_reg.busy;
   assign rd_valid               = st_reg.rv;
   assign rd_data                = st_reg.rd;
endmodule
`default_nettype wire

// ---- testbench/dcb_props.sv ----
// Purpose: Pin-level checks on the link between device and host ends
// Assumes: Host holds each select or strobe for several clk cycles
// Notes:   Pin effects reach outputs a few cycles late through input flops
`timescale 1ns/1ps
`default_nettype none
module dcb_checker (
   input wire logic       clk,
   input wire logic       arst_n,
   input wire logic       count_clock_a,
   input wire logic       counter_clear_n,
   input wire logic       capture_clock,
   input wire logic       carry_out_a_n,
   input wire logic       sel_a_low_byte_n,
   input wire logic       sel_a_high_byte_n,
   input wire logic       sel_b_low_byte_n,
   input wire logic       sel_b_high_byte_n,
   input wire logic [7:0] byte_out,
   input wire logic       byte_out_oe
);
   logic [3:0] sel_n;
   logic       idle;
   logic       one_sel;
   logic [7:0] ca_hist_reg;
   logic [7:0] clr_hist_reg;
   // Select decode
   assign sel_n   = {sel_b_high_byte_n, sel_b_low_byte_n, sel_a_high_byte_n, sel_a_low_byte_n};
   assign idle    = &sel_n;
   assign one_sel = $onehot(~sel_n);
   // Eight cycles of pin history, longer than the input flop lag
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ca_hist_reg  <= 8'h00;
         clr_hist_reg <= 8'hff;
      end else begin
         ca_hist_reg  <= {ca_hist_reg[6:0], count_clock_a};
         clr_hist_reg <= {clr_hist_reg[6:0], counter_clear_n};
      end
   end
   // **********
   // Properties
   // **********
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   property p_float; idle [*5] |-> !byte_out_oe; endproperty
   a_float: assert property (p_float) else $error("bus driven while idle");
   property p_float_soon; $rose(idle) |-> ##[1:6] !byte_out_oe; endproperty
   a_float_soon: assert property (p_float_soon) else $error("bus not released");
   property p_drive; (one_sel && $stable(sel_n)) [*5] |-> byte_out_oe; endproperty
   a_drive: assert property (p_drive) else $error("selected byte not driven");
   property p_drive_soon; $fell(idle) && one_sel |-> ##[1:6] byte_out_oe; endproperty
   a_drive_soon: assert property (p_drive_soon) else $error("bus enable late");
   property p_store_hold;
      (!capture_clock && $stable(sel_n)) [*6] |-> $stable(byte_out);
   endproperty
   a_store_hold: assert property (p_store_hold) else $error("byte moved without capture");
   property p_clear_carry; !counter_clear_n [*6] |-> carry_out_a_n; endproperty
   a_clear_carry: assert property (p_clear_carry) else $error("carry low during clear");
   property p_carry_quiet;
      ca_hist_reg == 8'h00 && clr_hist_reg == 8'hff |-> $stable(carry_out_a_n);
   endproperty
   a_carry_quiet: assert property (p_carry_quiet) else $error("carry moved while quiet");
   property p_carry_fall; $fell(carry_out_a_n) |-> |ca_hist_reg; endproperty
   a_carry_fall: assert property (p_carry_fall) else $error("carry fell without a count");
endmodule
`default_nettype wire

// ---- testbench/tb_dual_counter_byte_readout.sv ----
// Purpose: Random and corner checks of device and host ends joined pin to pin
// Assumes: Count pulses spaced eight cycles so the pin flop lag settles
// Notes:   Full count is out of reach in run time; carry checks stay in the checker
`timescale 1ns/1ps
`default_nettype none
module tb_dual_counter_byte_readout;
   logic        clk;
   logic        arst_n;
   logic        pulse_a;
   logic        pulse_b;
   logic        chain;
   logic        req;
   logic [2:0]  addr;
   logic        busy;
   logic        rd_valid;
   logic [7:0]  rd_data;
   logic [15:0] count_a;
   logic [15:0] count_b;
   logic [31:0] stored;
   logic [15:0] exp_a;
   logic [15:0] exp_b;
   logic [31:0] exp_store;
   logic [7:0]  got;
   int          err_count;
   int          samples_checked;
   int          seed;
   dcb_if dcb_if_inst ();
   dcb_device dcb_device_inst (.clk(clk), .arst_n(arst_n), .pins(dcb_if_inst),
      .count_a(count_a), .count_b(count_b), .stored(stored));
   dcb_host dcb_host_inst (.clk(clk), .arst_n(arst_n), .pins(dcb_if_inst), .pulse_a(pulse_a),
      .pulse_b(pulse_b), .chain(chain), .req(req), .addr(addr), .busy(busy),
      .rd_valid(rd_valid), .rd_data(rd_data));
   dcb_checker dcb_checker_inst (.clk(clk), .arst_n(arst_n),
      .count_clock_a(dcb_if_inst.count_clock_a), .counter_clear_n(dcb_if_inst.counter_clear_n),
      .capture_clock(dcb_if_inst.capture_clock), .carry_out_a_n(dcb_if_inst.carry_out_a_n),
      .sel_a_low_byte_n(dcb_if_inst.sel_a_low_byte_n),
      .sel_a_high_byte_n(dcb_if_inst.sel_a_high_byte_n),
      .sel_b_low_byte_n(dcb_if_inst.sel_b_low_byte_n),
      .sel_b_high_byte_n(dcb_if_inst.sel_b_high_byte_n),
      .byte_out(dcb_if_inst.byte_out), .byte_out_oe(dcb_if_inst.byte_out_oe));
   // 25 MHz clock
   initial clk = 1'b0;
   always #20 clk = ~clk;
   // Expected byte of the store for one read offset
   function automatic logic [7:0] exp_byte(input logic [2:0] o, input logic [31:0] s);
      return s[8*o +: 8];
   endfunction
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // One pulse then a quiet gap; chained B follows the gated carry
   task automatic pulse(input logic a, input logic b);
      @(posedge clk);
      #1 pulse_a = a;
      pulse_b = b;
      @(posedge clk);
      #1 pulse_a = 1'b0;
      pulse_b = 1'b0;
      repeat (7) @(posedge clk);
      #1 exp_a = exp_a + 16'(a);
      if (!chain)
         exp_b = exp_b + 16'(b);
   endtask
   // One host command, bounded wait on busy; read data caught on rd_valid
   task automatic host_op(input logic [2:0] a);
      int n;
      @(posedge clk);
      #1 req = 1'b1;
      addr = a;
      @(posedge clk);
      #1 req = 1'b0;
      n = 0;
      while (busy !== 1'b0 && n < 60) begin
         if (rd_valid === 1'b1)
            got = rd_data;
         @(posedge clk);
         #1 n = n + 1;
      end
      if (n >= 60)
         check(32'(n), 32'h0);
   endtask
   task automatic read_all();
      for (int i = 0; i < 4; i++) begin
         got = 8'hxx;
         host_op(3'(i));
         check({24'h0, got}, {24'h0, exp_byte(3'(i), exp_store)});
      end
   endtask
   // Watchdog well beyond the under one thousand cycles the run needs
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      report_and_stop();
   end
   // **********
   // Main flow
   // **********
   initial begin
      seed = 32'hfbb3;
      arst_n = 1'b0;
      {pulse_a, pulse_b, chain, req, addr} = 7'h00;
      {exp_a, exp_b, exp_store} = 64'h0;
      err_count = 0;
      samples_checked = 0;
      repeat (6) @(posedge clk);
      #1 arst_n = 1'b1;
      check({count_b, count_a}, 32'h0);
      check(stored, 32'h0);
      check({24'h0, dcb_if_inst.byte_bus}, 32'hff);
      for (int r = 0; r < 3; r++) begin
         for (int k = 0; k < 12; k++)
            pulse(1'($random(seed)), 1'($random(seed)));
         check({count_b, count_a}, {exp_b, exp_a});
         host_op(dcb_pkg::OFS_CAPTURE);
         exp_store = {exp_b, exp_a};
         check(stored, exp_store);
         pulse(1'b1, 1'b1);
         read_all();
      end
      host_op(3'h6);
      host_op(3'h7);
      check({count_b, count_a}, {exp_b, exp_a});
      chain = 1'b1;
      repeat (5) pulse(1'b1, 1'b1);
      check({count_b, count_a}, {exp_b, exp_a});
      host_op(dcb_pkg::OFS_CLEAR);
      {exp_a, exp_b} = 32'h0;
      check({count_b, count_a}, 32'h0);
      host_op(dcb_pkg::OFS_CAPTURE);
      exp_store = 32'h0;
      read_all();
      check({31'h0, dcb_if_inst.byte_out_oe}, 32'h0);
      report_and_stop();
   end
endmodule
`default_nettype wire
